// file: src/scrc_regs.svh
// register map and field layout of the clock-run control block
// assumes a 32-bit apb slave; the register index times four is the byte address
`ifndef SCRC_REGS_SVH
`define SCRC_REGS_SVH

`define SCRC_ADDR_W 12
`define SCRC_CRUN_INDEX 10'h05b
`define SCRC_CRUN_ADDR {`SCRC_CRUN_INDEX, 2'b00}
`define SCRC_CRUN_RESET 8'h00
`define SCRC_CRUN_WMASK 8'h1e
`define SCRC_BIT_STATUS 0
`define SCRC_BIT_SEC_EN 1
`define SCRC_BIT_KEEP 2
`define SCRC_BIT_PRI_EN 3
`define SCRC_BIT_MODE 4
`define SCRC_SYNC_STAGES 2

`endif

// file: src/scrc_pkg.sv
// types shared by the clock-run control block
// assumes the field positions of scrc_regs.svh
package scrc_pkg;

    // software-visible control fields, bit 0 is status and lives elsewhere
    typedef struct packed {
        logic idle_mode;
        logic pri_run_en;
        logic pri_keep;
        logic sec_run_en;
    } scrc_ctrl_type;

    // bridge-side events, all on clk
    typedef struct packed {
        logic pri_stop_req;
        logic pri_pending;
        logic downstream_txn;
        logic sec_idle;
    } scrc_evt_type;

    typedef enum logic {
        SCRC_RUN,
        SCRC_STOPPED
    } scrc_state_type;

endpackage : scrc_pkg

// file: src/scrc_sync2.sv
// two-stage synchroniser for levels entering the clk domain
// assumes nothing reads the first stage but the second
`timescale 1ns/1ns
module scrc_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule : scrc_sync2

// file: src/scrc_clk_run.sv
// secondary clock-run control with its apb control register
// assumes bridge events arrive on clk; the clock-run pin is asynchronous
//
// Functional notes
// [RULE1] with mode 0 the secondary clock stops only on a primary stop request.
// [RULE2] with mode 1 it stops when the secondary bus idles and nothing is pending upstream.
// [RULE3] a downstream transaction restarts a stopped secondary clock.
// [RULE4] an agent asserting the clock-run line makes the stopped clock restart.
// [RULE5] primary stop requests count only while primary clock run is enabled.
// [RULE6] keep-clock set always asks to keep the primary clock, else only while secondary runs.
// [RULE7] secondary clock-run enable gates all secondary stopping and resets to off.
// [RULE8] the status bit reads 1 while the secondary clock is stopped.
// [RULE9] bits 7 to 5 of the control register read as zero and ignore writes.
// [RULE10] the whole control register reads zero after reset.
// [RULE11] with secondary clock run off the clock never stops and status stays 0.
`include "scrc_regs.svh"
`timescale 1ns/1ns
module scrc_clk_run (
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SCRC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata_r,
    output logic pready_r,
    output logic pslverr_r,
    // bridge side
    input wire scrc_pkg::scrc_evt_type evt,
    input wire logic secondary_clock_keep_request_n,
    output logic sec_clk_stop_r,
    output logic pri_keep_clock_r
);

    logic rst_q_n;
    logic clkrun_q_n;
    scrc_pkg::scrc_ctrl_type ctrl_r;
    scrc_pkg::scrc_state_type state_r;
    scrc_pkg::scrc_state_type state_nxt;
    logic stop_cond;
    logic restart_cond;
    logic setup_ph;
    logic access_ph;
    logic wr_take;
    logic [7:0] crun_rd;

    // address decode shared by read and write paths
    function automatic logic crun_hit(input logic [`SCRC_ADDR_W-1:0] a);
        crun_hit = (a == `SCRC_CRUN_ADDR);
    endfunction : crun_hit

    // reset release through two flops; assertion stays asynchronous
    scrc_sync2 #(
        .WIDTH(1),
        .RESET_VAL(1'b0)
    ) u_rst_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(1'b1),
        .q(rst_q_n)
    );

    // clock-run pin is driven by secondary agents, so it is asynchronous
    scrc_sync2 #(
        .WIDTH(1),
        .RESET_VAL(1'b1)
    ) u_clkrun_sync (
        .clk(clk),
        .rst_n(rst_q_n),
        .d(secondary_clock_keep_request_n),
        .q(clkrun_q_n)
    );

    // apb phases
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable && pready_r;
    assign wr_take = access_ph && pwrite && crun_hit(paddr) && pstrb[0];

    // readback image, reserved top bits forced low
    // [RULE9] reserved bits zero
    // [RULE8] status from state
    assign crun_rd = {3'b000, ctrl_r.idle_mode, ctrl_r.pri_run_en,
                      ctrl_r.pri_keep, ctrl_r.sec_run_en,
                      (state_r == scrc_pkg::SCRC_STOPPED)};

    // control fields; only bits 4..1 are writable
    // [RULE10] zero after reset
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            ctrl_r <= '0;
        end else if (wr_take) begin
            ctrl_r.idle_mode <= pwdata[`SCRC_BIT_MODE];
            ctrl_r.pri_run_en <= pwdata[`SCRC_BIT_PRI_EN];
            ctrl_r.pri_keep <= pwdata[`SCRC_BIT_KEEP];
            ctrl_r.sec_run_en <= pwdata[`SCRC_BIT_SEC_EN];
        end
    end

    // no wait state: pready rises in the first access cycle
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup_ph;
        end
    end

    // read data and error captured at setup so they stand in access
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            pslverr_r <= !crun_hit(paddr); // unmapped word answers with an error
            if (!pwrite && crun_hit(paddr)) begin
                prdata_r <= {24'h00_0000, crun_rd};
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end else if (access_ph) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
    end

    // stop condition per policy
    always_comb begin
        stop_cond = 1'b0;
        if (ctrl_r.sec_run_en) begin
            if (ctrl_r.idle_mode) begin
                // [RULE2] idle policy
                stop_cond = evt.sec_idle && !evt.pri_pending;
            end else begin
                // [RULE1] request policy
                // [RULE5] primary enable gate
                stop_cond = evt.pri_stop_req && ctrl_r.pri_run_en;
            end
        end
    end

    // any reason to keep or bring back the clock outranks stopping
    // [RULE3] downstream restarts
    // [RULE4] clock-run line restarts
    // [RULE11] disabled never stops
    assign restart_cond = evt.downstream_txn || !clkrun_q_n || !ctrl_r.sec_run_en;

    // run/stop sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            scrc_pkg::SCRC_RUN: begin
                if (stop_cond && !restart_cond) begin
                    state_nxt = scrc_pkg::SCRC_STOPPED;
                end
            end
            scrc_pkg::SCRC_STOPPED: begin
                if (restart_cond) begin
                    state_nxt = scrc_pkg::SCRC_RUN;
                end
            end
            default: begin
                state_nxt = scrc_pkg::SCRC_RUN;
            end
        endcase
    end

    // [RULE7] state held running until enabled
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            state_r <= scrc_pkg::SCRC_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // clock gate request mirrors the next state so it lines up with status
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            sec_clk_stop_r <= 1'b0;
        end else begin
            sec_clk_stop_r <= (state_nxt == scrc_pkg::SCRC_STOPPED);
        end
    end

    // primary keep request; low only when allowed and secondary stopped
    // [RULE6] keep primary clock
    always_ff @(posedge clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            pri_keep_clock_r <= 1'b1; // safe default: clock kept while idle
        end else begin
            pri_keep_clock_r <= ctrl_r.pri_keep ||
                                (state_nxt != scrc_pkg::SCRC_STOPPED);
        end
    end

    // checks

    AST_REQ_STOP: assert property ( // RULE1
        @(posedge clk) disable iff (!rst_q_n)
        (state_r == scrc_pkg::SCRC_RUN && ctrl_r.sec_run_en && !ctrl_r.idle_mode
         && ctrl_r.pri_run_en && evt.pri_stop_req && !restart_cond)
        |=> sec_clk_stop_r && (state_r == scrc_pkg::SCRC_STOPPED))
        else $error("request policy did not stop the clock");

    AST_REQ_ONLY: assert property ( // RULE1
        @(posedge clk) disable iff (!rst_q_n)
        (!ctrl_r.idle_mode && !evt.pri_stop_req && state_r == scrc_pkg::SCRC_RUN
         && !wr_take)
        |=> state_r == scrc_pkg::SCRC_RUN)
        else $error("clock stopped without a primary request");

    AST_IDLE_STOP: assert property ( // RULE2
        @(posedge clk) disable iff (!rst_q_n)
        (state_r == scrc_pkg::SCRC_RUN && ctrl_r.sec_run_en && ctrl_r.idle_mode
         && evt.sec_idle && !evt.pri_pending && !restart_cond)
        |=> state_r == scrc_pkg::SCRC_STOPPED)
        else $error("idle policy did not stop the clock");

    AST_DOWN_RESTART: assert property ( // RULE3
        @(posedge clk) disable iff (!rst_q_n)
        (state_r == scrc_pkg::SCRC_STOPPED && evt.downstream_txn)
        |=> !sec_clk_stop_r && state_r == scrc_pkg::SCRC_RUN)
        else $error("downstream transaction did not restart the clock");

    AST_PIN_RESTART: assert property ( // RULE4
        @(posedge clk) disable iff (!rst_q_n)
        (state_r == scrc_pkg::SCRC_STOPPED && !secondary_clock_keep_request_n)
        |-> ##[1:3] state_r == scrc_pkg::SCRC_RUN)
        else $error("clock-run line did not restart the clock");

    AST_PRI_GATE: assert property ( // RULE5
        @(posedge clk) disable iff (!rst_q_n)
        $rose(sec_clk_stop_r) |-> $past(ctrl_r.idle_mode) || $past(ctrl_r.pri_run_en))
        else $error("stop honoured with primary clock run disabled");

    AST_KEEP: assert property ( // RULE6
        @(posedge clk) disable iff (!rst_q_n)
        (ctrl_r.pri_keep || state_nxt == scrc_pkg::SCRC_RUN) |=> pri_keep_clock_r)
        else $error("primary keep request dropped");

    AST_KEEP_RELEASE: assert property ( // RULE6
        @(posedge clk) disable iff (!rst_q_n)
        (!$past(ctrl_r.pri_keep) && sec_clk_stop_r) |-> !pri_keep_clock_r)
        else $error("primary keep held with secondary stopped");

    AST_SEC_OFF: assert property ( // RULE11
        @(posedge clk) disable iff (!rst_q_n)
        !ctrl_r.sec_run_en [*2] |-> !sec_clk_stop_r && state_r == scrc_pkg::SCRC_RUN)
        else $error("clock stopped with secondary clock run disabled");

    AST_SEC_GATE: assert property ( // RULE7
        @(posedge clk) disable iff (!rst_q_n)
        $rose(sec_clk_stop_r) |-> $past(ctrl_r.sec_run_en))
        else $error("stop without secondary clock run enable");

    AST_STATUS: assert property ( // RULE8
        @(posedge clk) disable iff (!rst_q_n)
        (setup_ph && !pwrite && crun_hit(paddr))
        |=> prdata_r[`SCRC_BIT_STATUS] == $past(sec_clk_stop_r))
        else $error("status bit disagrees with clock state");

    AST_RESERVED: assert property ( // RULE9
        @(posedge clk) disable iff (!rst_q_n)
        pready_r |-> prdata_r[31:5] == 27'h000_0000)
        else $error("reserved bits read nonzero");

    AST_RESET: assert property ( // RULE10
        @(posedge clk)
        !rst_q_n |-> crun_rd == `SCRC_CRUN_RESET && !sec_clk_stop_r)
        else $error("control register not zero in reset");

    // apb side: writes land, refused writes leave the fields alone
    AST_WRITE_LANDS: assert property ( // RULE7
        @(posedge clk) disable iff (!rst_q_n)
        wr_take
        |=> ctrl_r == $past(pwdata[`SCRC_BIT_MODE:`SCRC_BIT_SEC_EN]))
        else $error("control write did not land");

    AST_STRB_GUARD: assert property ( // RULE10
        @(posedge clk) disable iff (!rst_q_n)
        (access_ph && pwrite && !pstrb[0])
        |=> $stable(ctrl_r))
        else $error("write without byte strobe changed the register");

    AST_UNMAPPED: assert property ( // RULE9
        @(posedge clk) disable iff (!rst_q_n)
        (setup_ph && !crun_hit(paddr))
        |=> pslverr_r && prdata_r == 32'h0000_0000)
        else $error("unmapped access not refused");

    // clock-run side: refused stops and held states
    AST_IDLE_BUSY: assert property ( // RULE2
        @(posedge clk) disable iff (!rst_q_n)
        (state_r == scrc_pkg::SCRC_RUN && ctrl_r.idle_mode && !evt.sec_idle)
        |=> state_r == scrc_pkg::SCRC_RUN)
        else $error("idle policy stopped a busy bus");

    AST_IDLE_PEND: assert property ( // RULE2
        @(posedge clk) disable iff (!rst_q_n)
        (state_r == scrc_pkg::SCRC_RUN && ctrl_r.idle_mode && evt.pri_pending)
        |=> state_r == scrc_pkg::SCRC_RUN)
        else $error("idle policy stopped with primary requests pending");

    AST_PRI_OFF: assert property ( // RULE5
        @(posedge clk) disable iff (!rst_q_n)
        (state_r == scrc_pkg::SCRC_RUN && !ctrl_r.idle_mode && !ctrl_r.pri_run_en)
        |=> state_r == scrc_pkg::SCRC_RUN)
        else $error("request policy stopped with primary clock run off");

    AST_DOWN_HOLD: assert property ( // RULE3
        @(posedge clk) disable iff (!rst_q_n)
        evt.downstream_txn
        |=> !sec_clk_stop_r)
        else $error("clock stopped during a downstream transaction");

    AST_PIN_HOLD: assert property ( // RULE4
        @(posedge clk) disable iff (!rst_q_n)
        !clkrun_q_n
        |=> !sec_clk_stop_r)
        else $error("clock stopped while the clock-run line is asserted");

    AST_KEEP_FOLLOW: assert property ( // RULE6
        @(posedge clk) disable iff (!rst_q_n)
        !sec_clk_stop_r
        |-> pri_keep_clock_r)
        else $error("primary keep dropped while secondary runs");

    AST_STOP_HOLD: assert property ( // RULE3
        @(posedge clk) disable iff (!rst_q_n)
        (state_r == scrc_pkg::SCRC_STOPPED && !restart_cond)
        |=> state_r == scrc_pkg::SCRC_STOPPED)
        else $error("clock restarted without a cause");

    AST_STATUS_MIRROR: assert property ( // RULE8
        @(posedge clk) disable iff (!rst_q_n)
        (state_r == scrc_pkg::SCRC_STOPPED)
        |-> sec_clk_stop_r)
        else $error("gate request disagrees with stopped state");

    AST_SEC_DIS: assert property ( // RULE11
        @(posedge clk) disable iff (!rst_q_n)
        !ctrl_r.sec_run_en
        |=> !sec_clk_stop_r)
        else $error("clock stopped one cycle after secondary run disabled");

endmodule : scrc_clk_run

// file: dv/scrc_far_model.sv
// far side: primary central resource and secondary agents
// assumes its tasks are called from the clk domain only
`timescale 1ns/1ns
module scrc_far_model (
    input wire logic clk,
    output scrc_pkg::scrc_evt_type evt,
    output logic secondary_clock_keep_request_n
);
    // line released to its pull-up; events are set by the bench during reset
    initial begin
        secondary_clock_keep_request_n = 1'b1;
    end
    // event levels change just after an edge
    task automatic set_evt(input logic [3:0] e);
        @(posedge clk);
        evt <= e;
    endtask : set_evt
    // agent asks for clock
    // released line returns to the pull-up level, never a stale low
    task automatic ask_clock(input int hold);
        @(posedge clk);
        secondary_clock_keep_request_n <= 1'b0;
        repeat (hold) @(posedge clk);
        secondary_clock_keep_request_n <= 1'b1;
    endtask : ask_clock
endmodule : scrc_far_model

// file: dv/secondary_clock_run_control_tb_top.sv
// self-checking bench for the clock-run control block
// assumes a one-cycle apb answer and the far model for bridge events
`include "scrc_regs.svh"
`timescale 1ns/1ns
module secondary_clock_run_control_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    // bus fields are don't-care while psel is low
    logic pwrite;
    logic [`SCRC_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic sec_clk_stop_r;
    logic pri_keep_clock_r;
    logic req_n;
    scrc_pkg::scrc_evt_type evt;
    int n_errors = 0;
    int n_checks = 0;
    logic [31:0] rd;
    logic err;
    localparam logic [`SCRC_ADDR_W-1:0] CR = `SCRC_CRUN_ADDR;
    localparam logic [`SCRC_ADDR_W-1:0] BAD = 12'h168;
    // 100 MHz clock
    always #5 clk = ~clk;
    scrc_clk_run dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r), .evt(evt),
        .secondary_clock_keep_request_n(req_n), .sec_clk_stop_r(sec_clk_stop_r),
        .pri_keep_clock_r(pri_keep_clock_r));
    scrc_far_model far_u (.clk(clk), .evt(evt), .secondary_clock_keep_request_n(req_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [`SCRC_ADDR_W-1:0] a,
        input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        // no local limit: only the watchdog ends a wait
        do begin
            @(posedge clk);
        end while (pready_r !== 1'b1);
        rd = prdata_r;
        err = pslverr_r;
        chk({31'h0, pready_r}, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic stop_within(input logic exp, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            #1;
            if (sec_clk_stop_r === exp) break;
        end
        chk({31'h0, sec_clk_stop_r}, {31'h0, exp});
    endtask : stop_within
    // a cause that must be refused is watched for several cycles
    task automatic stop_hold(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
            chk({31'h0, sec_clk_stop_r}, 32'h0);
        end
    endtask : stop_hold
    task automatic t_reset;
        chk({30'h0, sec_clk_stop_r, pri_keep_clock_r}, 32'h1);
        apb(1'b0, CR, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_regs;
        apb(1'b1, CR, 32'hffffffff, 4'hf);
        apb(1'b0, CR, 32'h0, 4'h0);
        chk(rd, 32'h1e);
        apb(1'b1, CR, 32'h0, 4'he);
        apb(1'b0, CR, 32'h0, 4'h0);
        chk(rd, 32'h1e);
        apb(1'b1, BAD, 32'h0, 4'hf);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, BAD, 32'h0, 4'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        apb(1'b0, CR, 32'h0, 4'h0);
        chk(rd, 32'h1e);
        apb(1'b1, CR, 32'h0, 4'h1);
        $display("test regs done");
    endtask : t_regs
    task automatic t_mode0;
        apb(1'b1, CR, 32'h0a, 4'h1);
        far_u.set_evt(4'h1);
        stop_hold(6);
        far_u.set_evt(4'h9);
        stop_within(1'b1, 4);
        chk({31'h0, pri_keep_clock_r}, 32'h0);
        apb(1'b0, CR, 32'h0, 4'h0);
        chk(rd, 32'h0b);
        far_u.set_evt(4'h2);
        stop_within(1'b0, 3);
        chk({31'h0, pri_keep_clock_r}, 32'h1);
        apb(1'b1, CR, 32'h02, 4'h1);
        far_u.set_evt(4'h9);
        stop_hold(6);
        far_u.set_evt(4'h0);
        $display("test mode0 done");
    endtask : t_mode0
    task automatic t_mode1;
        apb(1'b1, CR, 32'h12, 4'h1);
        far_u.set_evt(4'h5);
        stop_hold(6);
        far_u.set_evt(4'h1);
        stop_within(1'b1, 4);
        fork
            far_u.ask_clock(6);
            stop_within(1'b0, 5);
        join
        stop_within(1'b1, 6);
        apb(1'b1, CR, 32'h16, 4'h1);
        // keep bit reaches the request one edge after the write lands
        @(posedge clk);
        #1;
        chk({30'h0, sec_clk_stop_r, pri_keep_clock_r}, 32'h3);
        apb(1'b1, CR, 32'h10, 4'h1);
        stop_within(1'b0, 4);
        $display("test mode1 done");
    endtask : t_mode1
    task automatic t_secoff;
        apb(1'b1, CR, 32'h18, 4'h1);
        far_u.set_evt(4'h9);
        stop_hold(6);
        apb(1'b0, CR, 32'h0, 4'h0);
        chk(rd, 32'h18);
        far_u.set_evt(4'h0);
        $display("test secoff done");
    endtask : t_secoff
    // reset in mid-run with the clock stopped must bring everything back
    task automatic t_midreset;
        far_u.set_evt(4'h1);
        apb(1'b1, CR, 32'h12, 4'h1);
        stop_within(1'b1, 4);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk({30'h0, sec_clk_stop_r, pri_keep_clock_r}, 32'h1);
        apb(1'b0, CR, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h0);
        far_u.set_evt(4'h0);
        $display("test midreset done");
    endtask : t_midreset
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test
    // main sequence, reset held 8 cycles then settled
    initial begin
        far_u.set_evt(4'h0);
        repeat (7) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_regs();
        t_mode0();
        t_mode1();
        t_secoff();
        t_midreset();
        finish_test();
    end
    // hang guard, far beyond the roughly 125 cycles needed
    initial begin
        #50000;
        n_errors++;
        finish_test();
    end
endmodule : secondary_clock_run_control_tb_top
